// ==== hw/gpio_status_pkg.sv ====
/*
 Constants for the four-pin general-purpose port, the status byte include
 switch and the reference configuration byte.
 Assumes register bytes sit in the low lane of 32-bit words, byte address
 equal to four times the register index.
*/
package gpio_status_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned REG_W    = 8;
   localparam int unsigned PINS     = 4;
   localparam int unsigned SYNC_LEN = 2;

   // ----------------------------------------------------------------
   // Register indices and reset values
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_CON_DIR  = 6'h04;
   localparam logic [5:0] IDX_DAT_STAT = 6'h05;
   localparam logic [5:0] IDX_REF      = 6'h06;

   localparam logic [7:0] RST_CON_DIR  = 8'h00;
   localparam logic [7:0] RST_DAT_STAT = 8'h00;
   localparam logic [7:0] RST_REF      = 8'h05;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned CON_LSB    = 4;
   localparam int unsigned DIR_LSB    = 0;
   localparam int unsigned DAT_LSB    = 0;
   localparam int unsigned STAT_BIT   = 6;
   localparam int unsigned REF_EN_BIT = 4;
   localparam int unsigned RSELP_LSB  = 2;
   localparam int unsigned RSELN_LSB  = 0;

   // Pin indices shared with the secondary reference inputs
   localparam int unsigned SHARED_POS_PIN = 0;
   localparam int unsigned SHARED_NEG_PIN = 1;

   localparam logic [1:0] SEL_SHARED_PIN = 2'h3;

endpackage

// ==== hw/adc_gpio_and_status_byte_ctrl.sv ====
/*
 General-purpose pin control with status byte include switch and
 reference configuration byte, reached over an Avalon-MM slave.
 Assumes pins are resolved outside from out and oe, and that the
 conversion data path reads status_byte_include.
*/
`timescale 1ns/1ps

// Notes on behaviour
// RL1: Upper nibble of mode two connects pins
// RL2: Pin one negative shared, pin zero positive
// RL3: Lower nibble of mode two sets direction
// RL4: Data write drives pin, read returns level
// RL5: Data bit one is high, resets low
// RL6: Bit six of mode three includes status
// RL7: Host writes zero to reserved bits
// RL8: Mode two at 04h, reset 00h
// RL9: Mode three at 05h, reset 00h
// RL10: Reference configuration at 06h, reset 05h
// RL11: Positive selector 11 picks shared pin
// RL12: Driver off when detached or input
module adc_gpio_and_status_byte_ctrl #(
   parameter int unsigned PIN_COUNT = gpio_status_pkg::PINS
) (
   input  wire logic                                sys_clk,
   input  wire logic                                rst_n,
   input  wire logic [gpio_status_pkg::ADDR_W-1:0]  avs_address,
   input  wire logic                                avs_read,
   input  wire logic                                avs_write,
   input  wire logic [gpio_status_pkg::DATA_W-1:0]  avs_writedata,
   output logic      [gpio_status_pkg::DATA_W-1:0]  avs_readdata,
   output logic                                     avs_waitrequest,
   input  wire logic [PIN_COUNT-1:0]                gpio_pin_in,
   output logic      [PIN_COUNT-1:0]                gpio_pin_out,
   output logic      [PIN_COUNT-1:0]                gpio_pin_oe,
   output logic                                     status_byte_include,
   output logic                                     internal_ref_enable,
   output logic      [1:0]                          pos_ref_select,
   output logic      [1:0]                          neg_ref_select,
   output logic                                     pos_ref_from_shared_pin,
   output logic                                     neg_ref_from_shared_pin
);
   import gpio_status_pkg::*;

   // Field layout is fixed to nibbles, so only four pins fit
   if (PIN_COUNT != PINS) begin : g_bad_pins
      $error("PIN_COUNT must be 4");
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [REG_W-1:0]     con_dir_r;
   logic [REG_W-1:0]     dat_stat_r;
   logic [REG_W-1:0]     ref_r;
   logic                 wait_r;
   logic [DATA_W-1:0]    rdata_r;
   logic [PIN_COUNT-1:0] oe_r;
   logic [PIN_COUNT-1:0] out_r;
   logic                 stat_r;
   logic                 pos_sh_r;
   logic                 neg_sh_r;
   logic [PIN_COUNT-1:0] sync1_r;
   logic [PIN_COUNT-1:0] sync2_r;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   wire [5:0] reg_idx = avs_address[ADDR_W-1:2];
   wire       aligned = (avs_address[1:0] == 2'h0);
   wire       hit_m2  = aligned && (reg_idx == IDX_CON_DIR);
   wire       hit_m3  = aligned && (reg_idx == IDX_DAT_STAT);
   wire       hit_ref = aligned && (reg_idx == IDX_REF);
   wire       req     = avs_read || avs_write;
   // Write commits on the one edge where waitrequest is low
   wire       wr_go   = avs_write && !wait_r;

   wire [PIN_COUNT-1:0] con_bits = con_dir_r[CON_LSB +: PIN_COUNT];
   wire [PIN_COUNT-1:0] dir_bits = con_dir_r[DIR_LSB +: PIN_COUNT];
   wire [PIN_COUNT-1:0] dat_bits = dat_stat_r[DAT_LSB +: PIN_COUNT];

   // Attached pins read the synchronised pin level, detached pins
   // read back the stored bit since nothing reaches them
   wire [PIN_COUNT-1:0] pin_view = (con_bits & sync2_r)
                                 | (~con_bits & dat_bits); // [RL4]
   wire [REG_W-1:0]     m3_view  = {dat_stat_r[REG_W-1:PIN_COUNT], pin_view};

   wire [REG_W-1:0] rd_byte = hit_m2  ? con_dir_r :
                              hit_m3  ? m3_view   :
                              hit_ref ? ref_r   : 8'h00;

   // Driver enable only when attached and set as output
   wire [PIN_COUNT-1:0] oe_nxt = con_bits & ~dir_bits; // [RL1] [RL3] [RL12]

   // ----------------------------------------------------------------
   // Bus slave: one wait cycle, then a one-cycle answer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else begin
         wait_r <= !(req && wait_r);
         if (avs_read && wait_r) begin
            rdata_r <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
         end
      end
   end

   // ----------------------------------------------------------------
   // Mode and reference registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         con_dir_r  <= RST_CON_DIR;  // [RL8]
         dat_stat_r <= RST_DAT_STAT; // [RL9] [RL5]
         ref_r      <= RST_REF;      // [RL10]
      end else if (wr_go) begin
         // Reserved bits are kept as written; software writes zero [RL7]
         if (hit_m2) begin
            con_dir_r <= avs_writedata[REG_W-1:0]; // [RL8]
         end
         if (hit_m3) begin
            dat_stat_r <= avs_writedata[REG_W-1:0]; // [RL9]
         end
         if (hit_ref) begin
            ref_r <= avs_writedata[REG_W-1:0]; // [RL10]
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin input synchronisers and output stage
   // ----------------------------------------------------------------
   for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            sync1_r[i] <= 1'b0;
            sync2_r[i] <= 1'b0;
            oe_r[i]    <= 1'b0;
            out_r[i]   <= 1'b0;
         end else begin
            sync1_r[i] <= gpio_pin_in[i];
            sync2_r[i] <= sync1_r[i];
            oe_r[i]    <= oe_nxt[i];   // [RL12]
            out_r[i]   <= dat_bits[i]; // [RL4] [RL5]
         end
      end
   end

   // ----------------------------------------------------------------
   // Status include and reference routing
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_r   <= 1'b0;
         pos_sh_r <= 1'b0;
         neg_sh_r <= 1'b0;
      end else begin
         stat_r   <= dat_stat_r[STAT_BIT]; // [RL6]
         // Shared pins: pin 0 positive, pin 1 negative [RL2]
         pos_sh_r <= (ref_r[RSELP_LSB +: 2] == SEL_SHARED_PIN); // [RL11]
         neg_sh_r <= (ref_r[RSELN_LSB +: 2] == SEL_SHARED_PIN); // [RL2]
      end
   end

   assign avs_waitrequest         = wait_r;
   assign avs_readdata            = rdata_r;
   assign gpio_pin_oe             = oe_r;
   assign gpio_pin_out            = out_r;
   assign status_byte_include     = stat_r;
   assign internal_ref_enable     = ref_r[REF_EN_BIT];
   assign pos_ref_select          = ref_r[RSELP_LSB +: 2];
   assign neg_ref_select          = ref_r[RSELN_LSB +: 2];
   assign pos_ref_from_shared_pin = pos_sh_r;
   assign neg_ref_from_shared_pin = neg_sh_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_detached_no_drive: assert property ( // [RL1]
      @(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> (gpio_pin_oe & ~$past(con_bits)) == 4'h0)
      else $error("detached pin driven");

   chk_shared_pin_oe: assert property ( // [RL2]
      @(posedge sys_clk) disable iff (!rst_n)
      ($past(con_bits[SHARED_NEG_PIN]) && !$past(dir_bits[SHARED_NEG_PIN]))
      |-> gpio_pin_oe[SHARED_NEG_PIN])
      else $error("shared negative pin not driven");

   chk_input_no_drive: assert property ( // [RL3]
      @(posedge sys_clk) disable iff (!rst_n)
      (dir_bits != 4'h0) |=> (gpio_pin_oe & $past(dir_bits)) == 4'h0)
      else $error("input pin driven");

   chk_pin_level: assert property ( // [RL4]
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_go && hit_m3) ##1 1'b1 |=>
      gpio_pin_out == $past(avs_writedata[DAT_LSB +: PIN_COUNT], 2))
      else $error("pin level not written value");

   chk_status_follow: assert property ( // [RL6]
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_go && hit_m3) ##1 1'b1 |=>
      status_byte_include == $past(avs_writedata[STAT_BIT], 2))
      else $error("status include wrong");

   chk_con_dir_write: assert property ( // [RL8]
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_go && hit_m2) |=> con_dir_r == $past(avs_writedata[REG_W-1:0]))
      else $error("mode two write lost");

   chk_dat_stat_read: assert property ( // [RL9]
      @(posedge sys_clk) disable iff (!rst_n)
      (avs_read && wait_r && hit_m3) |=>
      (!avs_waitrequest && avs_readdata[REG_W-1:0] == $past(m3_view)))
      else $error("mode three read wrong");

   chk_ref_write: assert property ( // [RL10]
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_go && hit_ref) ##1 1'b1 |=>
      pos_ref_select == $past(avs_writedata[RSELP_LSB +: 2], 2))
      else $error("reference write lost");

   chk_pos_shared: assert property ( // [RL11]
      @(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> pos_ref_from_shared_pin == ($past(pos_ref_select) == 2'h3))
      else $error("shared positive select wrong");

   chk_oe_rule: assert property ( // [RL12]
      @(posedge sys_clk) disable iff (!rst_n)
      $changed(con_dir_r) |=> gpio_pin_oe == $past(con_bits & ~dir_bits))
      else $error("driver enable mismatch");

   chk_bus_answer: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer timing wrong");

   chk_dat_stat_write: assert property ( // [RL9]
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_go && hit_m3) |=> dat_stat_r == $past(avs_writedata[REG_W-1:0]))
      else $error("mode three write lost");

   chk_ref_cfg_write: assert property ( // [RL10]
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_go && hit_ref) |=> ref_r == $past(avs_writedata[REG_W-1:0]))
      else $error("reference byte write lost");

   // A write that decodes to no register must leave all three alone
   chk_stray_write: assert property ( // [RL8] [RL9] [RL10]
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_go && !hit_m2 && !hit_m3 && !hit_ref) |=>
      ($stable(con_dir_r) && $stable(dat_stat_r) && $stable(ref_r)))
      else $error("stray write changed a register");

   chk_con_dir_read: assert property ( // [RL8]
      @(posedge sys_clk) disable iff (!rst_n)
      (avs_read && wait_r && hit_m2) |=>
      avs_readdata == {{(DATA_W-REG_W){1'b0}}, $past(con_dir_r)})
      else $error("mode two read wrong");

   chk_ref_cfg_read: assert property ( // [RL10]
      @(posedge sys_clk) disable iff (!rst_n)
      (avs_read && wait_r && hit_ref) |=>
      avs_readdata == {{(DATA_W-REG_W){1'b0}}, $past(ref_r)})
      else $error("reference byte read wrong");

   chk_stray_read: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (avs_read && wait_r && !hit_m2 && !hit_m3 && !hit_ref) |=>
      avs_readdata == 32'h0000_0000)
      else $error("stray read not zero");

   // Detached pins have nothing to sample, so the stored bit comes back
   chk_detached_readback: assert property ( // [RL4]
      @(posedge sys_clk) disable iff (!rst_n)
      (avs_read && wait_r && hit_m3) |=>
      ((avs_readdata[PIN_COUNT-1:0] ^ $past(dat_bits)) & ~$past(con_bits)) == 4'h0)
      else $error("detached pin readback wrong");

   chk_pin_follows_data: assert property ( // [RL5]
      @(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> gpio_pin_out == $past(dat_bits))
      else $error("pin level lags data bits");

   chk_status_tracks: assert property ( // [RL6]
      @(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> status_byte_include == $past(dat_stat_r[STAT_BIT]))
      else $error("status include lags control bit");

   chk_neg_shared: assert property ( // [RL2]
      @(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> neg_ref_from_shared_pin == ($past(neg_ref_select) == SEL_SHARED_PIN))
      else $error("shared negative select wrong");

   chk_shared_pos_oe: assert property ( // [RL2]
      @(posedge sys_clk) disable iff (!rst_n)
      ($past(con_bits[SHARED_POS_PIN]) && !$past(dir_bits[SHARED_POS_PIN]))
      |-> gpio_pin_oe[SHARED_POS_PIN])
      else $error("shared positive pin not driven");

   // Read data must stay put while no read is answered
   chk_rdata_hold: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !(avs_read && wait_r) |=> $stable(avs_readdata))
      else $error("read data moved without a read");

endmodule

// ==== verification/pin_partner.sv ====
/*
 External mux logic on the four port pins.
 Assumes the port drives a pin only while its output enable is high.
*/
`timescale 1ns/1ps
module pin_partner (
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe,
   input  wire logic [3:0] ext_level,
   output logic      [3:0] pin_level
);
   // ----------------------------------------------------------------
   // Wire resolution
   // ----------------------------------------------------------------
   // Far side drives each pin the port has let go, so no level floats
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ==== verification/tb_top.sv ====
/*
 Self-checking bench for the pin control block over Avalon-MM.
 Assumes one 10 MHz clock and the pin partner on the pin side.
*/
`timescale 1ns/1ps
module tb_top;
   import gpio_status_pkg::*;
   logic              sys_clk;
   logic              rst_n;
   logic [7:0]        avs_address;
   logic              avs_read;
   logic              avs_write;
   logic [31:0]       avs_writedata;
   logic [31:0]       avs_readdata;
   logic              avs_waitrequest;
   logic [3:0]        pin_level;
   logic [3:0]        pin_out;
   logic [3:0]        pin_oe;
   logic [3:0]        ext_level;
   logic              stat_inc;
   logic              ref_en;
   logic [1:0]        psel;
   logic [1:0]        nsel;
   logic              pos_sh;
   logic              neg_sh;
   logic [31:0]       exp_q[$];
   int                err_total;
   int                n_checks;

   adc_gpio_and_status_byte_ctrl uut (.sys_clk(sys_clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .gpio_pin_in(pin_level),
      .gpio_pin_out(pin_out), .gpio_pin_oe(pin_oe), .status_byte_include(stat_inc),
      .internal_ref_enable(ref_en), .pos_ref_select(psel), .neg_ref_select(nsel),
      .pos_ref_from_shared_pin(pos_sh), .neg_ref_from_shared_pin(neg_sh));
   pin_partner partner (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
      .pin_level(pin_level));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Request held until waitrequest is sampled low, released after that edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h0000_00, d};
      // No limit here: a hung slave is caught by the watchdog
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      // One edge with waitrequest high, then the answer edge
      chk("answer edges", 32'h0000_0002, n);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 8'h00);
   endtask

   // Readback monitor: oldest expectation against each answered read
   always @(posedge sys_clk) begin
      if (avs_read && avs_waitrequest === 1'b0) begin
         if (exp_q.size() == 0) chk("read queue", 32'h0000_0000, 32'h0000_0001);
         else chk("readdata", exp_q.pop_front(), avs_readdata);
      end
   end

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      #(100 * 20000);
      err_total++;
      test_done();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] m2;
      logic [3:0] dat;
      logic [3:0] lvl;
      logic       st;
      rst_n = 1'b0;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      ext_level = 4'h0;
      err_total = 0;
      n_checks = 0;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      void'($urandom(40));
      rd(8'h10, 32'h0000_0000);
      rd(8'h14, 32'h0000_0000);
      rd(8'h18, 32'h0000_0005);
      chk("oe at reset", 32'h0000_0000, {28'h0, pin_oe});
      bus(1'b1, 8'h1C, 8'hFF);
      rd(8'h1C, 32'h0000_0000);
      rd(8'h11, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      for (int i = 0; i < 12; i++) begin
         m2 = 8'($urandom());
         dat = 4'($urandom());
         st = 1'($urandom());
         bus(1'b1, 8'h10, m2);
         bus(1'b1, 8'h14, {1'b0, st, 2'b00, dat});
         ext_level <= 4'($urandom());
         repeat (4) @(posedge sys_clk);
         chk("oe", {28'h0, m2[7:4] & ~m2[3:0]}, {28'h0, pin_oe});
         chk("out", {28'h0, dat & m2[7:4] & ~m2[3:0]},
             {28'h0, pin_out & pin_oe});
         chk("status include", {31'h0, st}, {31'h0, stat_inc});
         lvl = (m2[7:4] & ~m2[3:0] & dat) | ~(m2[7:4] & ~m2[3:0]) & ext_level;
         rd(8'h14, {24'h0, 1'b0, st, 2'b00, (m2[7:4] & lvl) | (~m2[7:4] & dat)});
         rd(8'h10, {24'h0, m2});
      end
      for (int c = 0; c < 32; c++) begin
         bus(1'b1, 8'h18, 8'(c));
         repeat (2) @(posedge sys_clk);
         chk("ref select", {27'h0, c[4:0]}, {27'h0, ref_en, psel, nsel});
         chk("pos shared", {31'h0, c[3:2] == 2'h3}, {31'h0, pos_sh});
         chk("neg shared", {31'h0, c[1:0] == 2'h3}, {31'h0, neg_sh});
         rd(8'h18, {24'h0, 8'(c)});
      end
      // Reset in mid-run, after the registers have been rewritten
      rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk("oe in reset", 32'h0000_0000, {28'h0, pin_oe});
      chk("out in reset", 32'h0000_0000, {28'h0, pin_out});
      chk("status in reset", 32'h0000_0000, {31'h0, stat_inc});
      chk("ref in reset", 32'h0000_0005, {27'h0, ref_en, psel, nsel});
      rst_n <= 1'b1;
      rd(8'h10, 32'h0000_0000);
      rd(8'h14, 32'h0000_0000);
      rd(8'h18, 32'h0000_0005);
      repeat (3) @(posedge sys_clk);
      chk("queue empty", 32'h0000_0000, exp_q.size());
      test_done();
   end
endmodule
